/* rtl/rss_pkg.sv */
// Constants, register map and types of the reset source sequencer
package rss_pkg;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int CLK_KHZ       = 200_000;
	localparam int SLOW_KHZ      = 512;
	localparam int SLOW_DIV      = CLK_KHZ / SLOW_KHZ;
	localparam int BIAS_US       = 10;
	localparam int FALLBACK_US   = 100;
	localparam int POWERUP_TIMER_A_MS     = 4;
	localparam int POWERUP_TIMER_B_MS     = 16;
	localparam int POWERUP_TIMER_C_MS     = 64;
	localparam int FILTER_NS     = 200;
	localparam int BIAS_TICKS    = (BIAS_US * SLOW_KHZ + 999) / 1000;
	localparam int FALLBACK_TICKS = (FALLBACK_US * SLOW_KHZ + 999) / 1000;
	localparam int POWERUP_TIMER_A_TICKS  = POWERUP_TIMER_A_MS * SLOW_KHZ;
	localparam int POWERUP_TIMER_B_TICKS  = POWERUP_TIMER_B_MS * SLOW_KHZ;
	localparam int POWERUP_TIMER_C_TICKS  = POWERUP_TIMER_C_MS * SLOW_KHZ;
	localparam int FILTER_CYC    = (FILTER_NS * CLK_KHZ + 999_999) / 1_000_000;

	// ---------------------------------------------------------------
	// Register map
	// ---------------------------------------------------------------
	localparam logic [3:0] ADDR_RESET_CTRL = 4'h0;
	localparam logic [3:0] ADDR_OSC_CTRL   = 4'h4;
	localparam logic [3:0] ADDR_CONFIG     = 4'h8;

	// reset_control_reg fields
	localparam int RC_TRAP  = 15;
	localparam int RC_ILL   = 14;
	localparam int RC_EXT   = 7;
	localparam int RC_SWR   = 6;
	localparam int RC_WDTO  = 4;
	localparam int RC_SLEEP = 3;
	localparam int RC_IDLE  = 2;
	localparam int RC_BOR   = 1;
	localparam int RC_POR   = 0;
	localparam logic [15:0] RC_MASK  = 16'hC0DF;
	localparam logic [15:0] RC_RESET = 16'h0003;

	// osc_control_reg fields
	localparam int OC_COSC_LO = 12;
	localparam int OC_LOCK    = 5;
	localparam int OC_CF      = 3;

	// configuration register fields
	localparam int CF_POWERUP_TIMER_LO  = 0;
	localparam int CF_CLOCK_FAIL_MONITOR     = 2;
	localparam int CF_XTAL     = 3;
	localparam int CF_BOR_EN   = 4;
	localparam int CF_BORL_LO  = 5;
	localparam int CF_GRP_LO   = 8;
	localparam int CF_PRI_LO   = 16;
	localparam logic [31:0] CF_MASK  = 32'h001F_077F;
	localparam logic [31:0] CF_RESET = 32'h0007_0713;

	// ---------------------------------------------------------------
	// Encodings
	// ---------------------------------------------------------------
	localparam logic [2:0] GRP_FRC  = 3'h1;
	localparam logic [2:0] GRP_SLOW_INTERNAL_OSC = 3'h2;
	localparam logic [4:0] PRI_PLL4  = 5'h01;
	localparam logic [4:0] PRI_PLL8  = 5'h0A;
	localparam logic [4:0] PRI_PLL16 = 5'h03;
	localparam logic [1:0] POWERUP_TIMER_NONE = 2'h0;
	localparam logic [1:0] POWERUP_TIMER_A    = 2'h1;
	localparam logic [1:0] POWERUP_TIMER_B    = 2'h2;

	typedef enum logic [2:0] {
		ST_BIAS,
		ST_POWERUP_TIMER,
		ST_HOLD,
		ST_PHASE,
		ST_RUN
	} rss_state_t;

endpackage : rss_pkg

/* rtl/rss_reset_source_sequencer.sv */
// Reset source sequencer: cause flags, power-up delays, clock hold
//
// Overview of operation
// - Distinguish seven reset causes
// - Watchdog wake in sleep causes no reset
// - Cause flags set or cleared per cause
// - Pin path filters out short pulses
// - Reset pin is input only
// - Supply rise resets timers and whole device
// - Power-on loads clock source from configuration
// - Bias settle delay precedes power-up timing
// - Power-up timeout none, 4, 16, 64 ms
// - Release reset on first clock phase edge
// - Clock not ready with monitor on traps
// - Clock failure trap switches to fast osc
// - No monitor, no timeout, no crystal: leave reset right after bias delay
// - No monitor, no clock: stay in reset
// - Brown-out with four levels resets device
// - Brown-out reloads clock source from configuration
// - Brown-out starts startup timer, waits lock
// - Brown-out applies bias and power-up delays
// - Zero timeout with crystal uses 100 us
// - Brown-out sets brown-out flag bit 1
// - Brown-out stays active in sleep, idle
// - Flags writable; power-on sets two flags
// - Timers run from slow osc; it stops in run unless monitor on
`timescale 1ns/1ps
`default_nettype none

module rss_reset_source_sequencer
	import rss_pkg::*;
#(
	parameter int POWERUP_TIMER_A_CNT = rss_pkg::POWERUP_TIMER_A_TICKS,
	parameter int POWERUP_TIMER_B_CNT = rss_pkg::POWERUP_TIMER_B_TICKS,
	parameter int POWERUP_TIMER_C_CNT = rss_pkg::POWERUP_TIMER_C_TICKS
) (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        supply_rise,
	input  wire logic        brownout_detect,
	input  wire logic        external_reset_pin_n,
	input  wire logic        sleep_mode,
	input  wire logic        idle_mode,
	input  wire logic        watchdog_timeout,
	input  wire logic        reset_instr,
	input  wire logic        trap_lockup,
	input  wire logic        illegal_op,
	input  wire logic        osc_running,
	input  wire logic        osc_startup_done,
	input  wire logic        pll_lock,
	input  wire logic        first_clock_phase,
	output logic             system_reset,
	output logic      [2:0]  clock_select,
	output logic             clock_fail_trap,
	output logic             osc_startup_start,
	output logic             watchdog_wake,
	output logic             slow_osc_enable,
	output logic      [1:0]  brownout_level
);
	import rss_pkg::*;

	// ---------------------------------------------------------------
	// Declarations
	// ---------------------------------------------------------------
	localparam logic [8:0]  DIV_LAST = 9'(SLOW_DIV - 1);
	localparam logic [7:0]  FLT_LAST = 8'(FILTER_CYC - 1);

	rss_state_t  state_q;
	logic [15:0] cnt_q;
	logic [8:0]  div_q;
	logic        tick_q;
	logic [7:0]  flt_q;
	logic        ext_active_q;
	logic [15:0] rc_q;
	logic [2:0]  cosc_q;
	logic        cf_q;
	logic [31:0] cfg_q;
	logic [31:0] act_q;
	logic        trap_q;
	logic        ost_q;
	logic        wake_q;
	logic        slow_en_q;
	logic        wait_q;
	logic [31:0] rdata_q;

	logic        bor_ev;
	logic        cold_ev;
	logic        ext_rise;
	logic        wdt_reset;
	logic        wdt_wake;
	logic        warm_ev;
	logic        clk_ready;
	logic        uses_pll_act;
	logic        req;
	logic        acc;
	logic [15:0] powerup_timer_load;

	function automatic logic uses_pll(input logic [4:0] pri);
		uses_pll = (pri == PRI_PLL4) || (pri == PRI_PLL8) ||
			(pri == PRI_PLL16);
	endfunction : uses_pll

	// ---------------------------------------------------------------
	// Event decode
	// ---------------------------------------------------------------
	// Level, not edge: reset stays applied while the supply is low
	assign bor_ev    = cfg_q[CF_BOR_EN] && brownout_detect;
	assign cold_ev   = supply_rise || bor_ev;
	assign ext_rise  = !external_reset_pin_n && !ext_active_q &&
		(flt_q == FLT_LAST);
	assign wdt_reset = watchdog_timeout && !sleep_mode;
	assign wdt_wake  = watchdog_timeout && sleep_mode;
	assign warm_ev   = ext_rise || wdt_reset || reset_instr ||
		trap_lockup || illegal_op;
	assign uses_pll_act = uses_pll(act_q[CF_PRI_LO +: 5]);

	always_comb
	begin
		if (cosc_q == GRP_FRC || cosc_q == GRP_SLOW_INTERNAL_OSC)
			clk_ready = 1'b1;
		else
			clk_ready = (!act_q[CF_XTAL] ||
				(osc_running && osc_startup_done)) &&
				(!uses_pll_act || pll_lock);
	end

	always_comb
	begin
		unique case (act_q[CF_POWERUP_TIMER_LO +: 2])
			POWERUP_TIMER_NONE:
				powerup_timer_load = act_q[CF_XTAL] ?
					16'(FALLBACK_TICKS) : 16'h0000;
			POWERUP_TIMER_A:   powerup_timer_load = 16'(POWERUP_TIMER_A_CNT);
			POWERUP_TIMER_B:   powerup_timer_load = 16'(POWERUP_TIMER_B_CNT);
			default:  powerup_timer_load = 16'(POWERUP_TIMER_C_CNT);
		endcase
	end

	// ---------------------------------------------------------------
	// Slow oscillator tick
	// ---------------------------------------------------------------
	// Brown-out restarts the delays too, so the tick must come back
	always_ff @(posedge clk)
	begin
		if (rst || cold_ev)
			slow_en_q <= 1'b1;
		else if (state_q == ST_RUN && !act_q[CF_CLOCK_FAIL_MONITOR])
			slow_en_q <= 1'b0;
	end

	always_ff @(posedge clk)
	begin
		if (rst || !slow_en_q)
		begin
			div_q  <= 9'h000;
			tick_q <= 1'b0;
		end
		else
		begin
			tick_q <= (div_q == DIV_LAST);
			div_q  <= (div_q == DIV_LAST) ? 9'h000 : div_q + 9'h001;
		end
	end

	// ---------------------------------------------------------------
	// Reset pin filter
	// ---------------------------------------------------------------
	// Pin is only sampled; nothing here can drive it
	always_ff @(posedge clk)
	begin
		if (rst || external_reset_pin_n)
		begin
			flt_q        <= 8'h00;
			ext_active_q <= 1'b0;
		end
		else if (flt_q != FLT_LAST)
			flt_q <= flt_q + 8'h01;
		else
			ext_active_q <= 1'b1;
	end

	// ---------------------------------------------------------------
	// Sequencer
	// ---------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (rst || cold_ev)
		begin
			state_q <= ST_BIAS;
			cnt_q   <= 16'(BIAS_TICKS);
		end
		else if (warm_ev)
			state_q <= ST_PHASE;
		else
		begin
			unique case (state_q)
				ST_BIAS:
					if (cnt_q == 16'h0000)
					begin
						state_q <= ST_POWERUP_TIMER;
						cnt_q   <= powerup_timer_load;
					end
					else if (tick_q)
						cnt_q <= cnt_q - 16'h0001;
				ST_POWERUP_TIMER:
					if (cnt_q != 16'h0000)
					begin
						if (tick_q)
							cnt_q <= cnt_q - 16'h0001;
					end
					else if (clk_ready || act_q[CF_CLOCK_FAIL_MONITOR])
						state_q <= ST_PHASE;
					else
						state_q <= ST_HOLD;
				ST_HOLD:
					if (clk_ready)
						state_q <= ST_PHASE;
				ST_PHASE:
					if (first_clock_phase && !ext_active_q)
						state_q <= ST_RUN;
				ST_RUN:
					state_q <= ST_RUN;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			act_q <= CF_RESET;
		else if (cold_ev)
			act_q <= cfg_q;
	end

	always_ff @(posedge clk)
	begin
		trap_q <= 1'b0;
		if (rst)
		begin
			cosc_q <= CF_RESET[CF_GRP_LO +: 3];
			cf_q   <= 1'b0;
		end
		else if (cold_ev)
		begin
			cosc_q <= cfg_q[CF_GRP_LO +: 3];
			cf_q   <= 1'b0;
		end
		else if (!warm_ev && state_q == ST_POWERUP_TIMER && cnt_q == 16'h0000 &&
			act_q[CF_CLOCK_FAIL_MONITOR] && !clk_ready)
		begin
			trap_q <= 1'b1;
			cosc_q <= GRP_FRC;
			cf_q   <= 1'b1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			ost_q  <= 1'b0;
			wake_q <= 1'b0;
		end
		else
		begin
			ost_q  <= cold_ev && cfg_q[CF_XTAL];
			wake_q <= wdt_wake && !cold_ev && !warm_ev;
		end
	end

	// ---------------------------------------------------------------
	// Reset cause flags
	// ---------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (rst || supply_rise)
			rc_q <= RC_RESET;
		else if (bor_ev)
		begin
			rc_q[RC_POR] <= 1'b0;
			rc_q[RC_BOR] <= 1'b1;
		end
		else if (ext_rise)
		begin
			rc_q[RC_EXT]   <= 1'b1;
			rc_q[RC_WDTO]  <= 1'b0;
			rc_q[RC_SLEEP] <= sleep_mode;
			rc_q[RC_IDLE]  <= idle_mode && !sleep_mode;
			if (!sleep_mode && !idle_mode)
				rc_q[RC_SWR] <= 1'b0;
		end
		else if (watchdog_timeout)
		begin
			rc_q[RC_WDTO] <= 1'b1;
			if (!sleep_mode)
			begin
				rc_q[RC_EXT]   <= 1'b0;
				rc_q[RC_SWR]   <= 1'b0;
				rc_q[RC_SLEEP] <= 1'b0;
				rc_q[RC_IDLE]  <= 1'b0;
			end
			else
				rc_q[RC_SLEEP] <= 1'b1;
		end
		else if (reset_instr)
		begin
			rc_q[RC_SWR]   <= 1'b1;
			rc_q[RC_EXT]   <= 1'b0;
			rc_q[RC_WDTO]  <= 1'b0;
			rc_q[RC_SLEEP] <= 1'b0;
			rc_q[RC_IDLE]  <= 1'b0;
		end
		else if (trap_lockup || illegal_op)
		begin
			if (trap_lockup)
				rc_q[RC_TRAP] <= 1'b1;
			if (illegal_op)
				rc_q[RC_ILL] <= 1'b1;
		end
		// Hardware events win over a write in the same cycle
		else if (acc && avs_write && avs_address == ADDR_RESET_CTRL)
			rc_q <= avs_writedata[15:0] & RC_MASK;
	end

	// ---------------------------------------------------------------
	// Avalon-MM slave
	// ---------------------------------------------------------------
	assign req = avs_read || avs_write;
	assign acc = req && !wait_q;

	always_ff @(posedge clk)
	begin
		if (rst)
			wait_q <= 1'b1;
		else
			wait_q <= !(req && wait_q);
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			cfg_q <= CF_RESET;
		else if (acc && avs_write && avs_address == ADDR_CONFIG)
			cfg_q <= avs_writedata & CF_MASK;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			rdata_q <= 32'h0000_0000;
		else if (avs_read && wait_q)
		begin
			unique case (avs_address)
				ADDR_RESET_CTRL: rdata_q <= {16'h0000, rc_q};
				ADDR_OSC_CTRL:
				begin
					rdata_q <= 32'h0000_0000;
					rdata_q[OC_COSC_LO +: 3] <= cosc_q;
					rdata_q[OC_LOCK] <= pll_lock;
					rdata_q[OC_CF]   <= cf_q;
				end
				ADDR_CONFIG:     rdata_q <= cfg_q;
				default:         rdata_q <= 32'h0000_0000;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign avs_readdata      = rdata_q;
	assign avs_waitrequest   = wait_q;
	assign system_reset      = (state_q != ST_RUN);
	assign clock_select      = cosc_q;
	assign clock_fail_trap   = trap_q;
	assign osc_startup_start = ost_q;
	assign watchdog_wake     = wake_q;
	assign slow_osc_enable   = slow_en_q;
	assign brownout_level    = cfg_q[CF_BORL_LO +: 2];

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	chk_release_on_phase: assert property (@(posedge clk) disable iff (rst)
		$fell(system_reset) |-> $past(first_clock_phase))
		else $error("reset released off the clock phase");

	chk_power_on_flags: assert property (@(posedge clk) disable iff (rst)
		supply_rise |=> rc_q[RC_POR] && rc_q[RC_BOR] && system_reset)
		else $error("power-on flags or reset wrong");

	chk_brownout_flag: assert property (@(posedge clk) disable iff (rst)
		bor_ev && !supply_rise |=> rc_q[RC_BOR] && !rc_q[RC_POR])
		else $error("brown-out flag not set");

	chk_filter_short: assert property (@(posedge clk) disable iff (rst)
		$rose(ext_active_q) |-> $past(!external_reset_pin_n, 2))
		else $error("short pin pulse accepted");

	chk_trap_fast_osc: assert property (@(posedge clk) disable iff (rst)
		trap_q |-> cosc_q == GRP_FRC && cf_q && state_q == ST_PHASE)
		else $error("trap without fast osc switch");

	chk_wake_no_reset: assert property (@(posedge clk) disable iff (rst)
		wake_q && $past(state_q == ST_RUN) |-> !system_reset)
		else $error("watchdog wake caused reset");

	chk_bias_first: assert property (@(posedge clk) disable iff (rst)
		cold_ev |=> state_q == ST_BIAS ##1 state_q == ST_BIAS)
		else $error("bias delay skipped");

	chk_hold_no_clock: assert property (@(posedge clk) disable iff (rst)
		state_q == ST_HOLD && !clk_ready && !cold_ev && !warm_ev
		|=> state_q == ST_HOLD && system_reset)
		else $error("left hold without clock");

	chk_cold_reload: assert property (@(posedge clk) disable iff (rst)
		cold_ev |=> cosc_q == $past(cfg_q[CF_GRP_LO +: 3]))
		else $error("clock source not reloaded");

	chk_bus_one_wait: assert property (@(posedge clk) disable iff (rst)
		req && avs_waitrequest |=> !avs_waitrequest)
		else $error("waitrequest held too long");

endmodule : rss_reset_source_sequencer

`default_nettype wire

/* tb/rss_partner_model.sv */
// Far-side model: supply monitors, reset pin and oscillator
`timescale 1ns/1ps
`default_nettype none

module rss_partner_model #(
	parameter int STARTUP = 200
) (
	input  wire logic clk,
	input  wire logic por_go,
	input  wire logic sag,
	input  wire logic pin_low,
	input  wire logic osc_dead,
	input  wire logic osc_startup_start,
	output logic      supply_rise,
	output logic      brownout_detect,
	output logic      external_reset_pin_n,
	output logic      osc_running,
	output logic      osc_startup_done,
	output logic      pll_lock,
	output logic      first_clock_phase
);
	int         cnt = STARTUP + 20;
	logic [1:0] ph  = 2'h0;

	assign supply_rise          = por_go;
	assign brownout_detect      = sag;
	assign external_reset_pin_n = !pin_low;

	// Restart on every start request; lock lags, so a hold is visible
	always @(posedge clk)
	begin
		if (osc_dead || osc_startup_start)
			cnt <= 0;
		else if (cnt < STARTUP + 20)
			cnt <= cnt + 1;
		ph <= ph + 2'h1;
	end

	assign osc_running       = cnt >= STARTUP / 2;
	assign osc_startup_done  = cnt >= STARTUP;
	assign pll_lock          = cnt >= STARTUP + 20;
	assign first_clock_phase = ph == 2'h0;
endmodule : rss_partner_model

`default_nettype wire

/* tb/rss_reset_source_sequencer_tb_top.sv */
// Self-checking testbench of the reset source sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin failures++; $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end

module rss_reset_source_sequencer_tb_top;
	import rss_pkg::*;
	// ---------------------------------------------------------------
	// Signals
	// ---------------------------------------------------------------
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [3:0]  avs_address = 4'h0;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        por_go = 1'b0;
	logic        sag = 1'b0;
	logic        pin_low = 1'b0;
	logic        osc_dead = 1'b0;
	logic        sleep_mode = 1'b0;
	logic        watchdog_timeout = 1'b0;
	logic        reset_instr = 1'b0;
	logic        trap_lockup = 1'b0;
	logic        illegal_op = 1'b0;
	logic        supply_rise, brownout_detect, external_reset_pin_n;
	logic        osc_running, osc_startup_done, pll_lock;
	logic        first_clock_phase, system_reset, clock_fail_trap;
	logic        osc_startup_start, watchdog_wake, slow_osc_enable;
	logic [2:0]  clock_select;
	logic [1:0]  brownout_level;
	logic [31:0] q [$];
	logic [31:0] want;
	logic [31:0] v;
	logic [15:0] wexp [5] = '{16'h0083, 16'h0013, 16'h0043, 16'h8003,
		16'h4003};
	int          failures = 0;
	int          n_checks = 0;
	int          cyc = 0;
	int          tw = 0;
	int          tt = 0;
	int          to = 0;
	int          t0;
	int          k;

	always #2.5 clk = ~clk;

	rss_reset_source_sequencer #(.POWERUP_TIMER_A_CNT(4), .POWERUP_TIMER_B_CNT(8),
		.POWERUP_TIMER_C_CNT(16)) i_rss_reset_source_sequencer (.clk(clk),
		.rst(rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.supply_rise(supply_rise), .brownout_detect(brownout_detect),
		.external_reset_pin_n(external_reset_pin_n),
		.sleep_mode(sleep_mode), .idle_mode(1'b0),
		.watchdog_timeout(watchdog_timeout), .reset_instr(reset_instr),
		.trap_lockup(trap_lockup), .illegal_op(illegal_op),
		.osc_running(osc_running), .osc_startup_done(osc_startup_done),
		.pll_lock(pll_lock), .first_clock_phase(first_clock_phase),
		.system_reset(system_reset), .clock_select(clock_select),
		.clock_fail_trap(clock_fail_trap),
		.osc_startup_start(osc_startup_start),
		.watchdog_wake(watchdog_wake), .slow_osc_enable(slow_osc_enable),
		.brownout_level(brownout_level));

	rss_partner_model i_rss_partner_model (.clk(clk), .por_go(por_go),
		.sag(sag), .pin_low(pin_low), .osc_dead(osc_dead),
		.osc_startup_start(osc_startup_start), .supply_rise(supply_rise),
		.brownout_detect(brownout_detect),
		.external_reset_pin_n(external_reset_pin_n),
		.osc_running(osc_running), .osc_startup_done(osc_startup_done),
		.pll_lock(pll_lock), .first_clock_phase(first_clock_phase));

	// ---------------------------------------------------------------
	// Monitors
	// ---------------------------------------------------------------
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (watchdog_wake)
			tw <= cyc;
		if (clock_fail_trap)
			tt <= cyc;
		if (osc_startup_start)
			to <= cyc;
		if (avs_read && avs_waitrequest === 1'b0)
		begin
			want = q.pop_front();
			`CHK(avs_readdata, want)
		end
	end

	// ---------------------------------------------------------------
	// Tasks
	// ---------------------------------------------------------------
	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		avs_address   <= a;
		avs_writedata <= d;
		avs_write     <= 1'b1;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		avs_write <= 1'b0;
	endtask : wr

	task rd(input logic [3:0] a, input logic [31:0] e);
		q.push_back(e);
		@(posedge clk);
		avs_address <= a;
		avs_read    <= 1'b1;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		avs_read <= 1'b0;
	endtask : rd

	// 0 pin, 1 watchdog, 2 instr, 3 trap, 4 illegal, 5 sag, 6 power-on
	task ev(input int n);
		@(posedge clk);
		case (n)
			0: pin_low <= 1'b1;
			1: watchdog_timeout <= 1'b1;
			2: reset_instr <= 1'b1;
			3: trap_lockup <= 1'b1;
			4: illegal_op <= 1'b1;
			5: sag <= 1'b1;
			default: por_go <= 1'b1;
		endcase
		repeat (n == 0 ? 60 : 1) @(posedge clk);
		{pin_low, watchdog_timeout, reset_instr, trap_lockup} <= 4'h0;
		{illegal_op, sag, por_go} <= 3'h0;
	endtask : ev

	// Release must follow a first-phase pulse by one cycle
	task wait_rel;
		logic ph;
		ph = 1'b0;
		repeat (2) @(posedge clk);
		for (int i = 0; i < 40000 && system_reset !== 1'b0; i++)
		begin
			ph = first_clock_phase;
			@(posedge clk);
		end
		`CHK(ph, 1'b1)
	endtask : wait_rel

	function automatic logic in_win(input int s, input int t);
		return (cyc - s) >= (t + 5) * SLOW_DIV
			&& (cyc - s) <= (t + 8) * SLOW_DIV;
	endfunction : in_win

	task cold(input logic [31:0] c, input int n, input int t);
		int s;
		wr(ADDR_CONFIG, c);
		ev(n);
		s = cyc;
		wait_rel;
		`CHK(in_win(s, t), 1'b1)
	endtask : cold

	task tdone(input string n);
		$display("test %s done at %0t", n, $time);
	endtask : tdone

	task end_sim;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : end_sim

	// ---------------------------------------------------------------
	// Sequence
	// ---------------------------------------------------------------
	initial
	begin
		void'($urandom(32'hDFF78E9E));
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		t0 = cyc;
		`CHK(slow_osc_enable, 1'b1)
		`CHK(clock_select, 3'h7)
		rd(ADDR_RESET_CTRL, 32'h3);
		rd(ADDR_CONFIG, 32'h0007_0713);
		rd(4'hC, 32'h0);
		wait_rel;
		`CHK(in_win(t0, 16), 1'b1)
		v = $urandom;
		wr(ADDR_RESET_CTRL, v);
		rd(ADDR_RESET_CTRL, {16'h0, v[15:0] & RC_MASK});
		wr(ADDR_OSC_CTRL, v);
		rd(ADDR_OSC_CTRL, 32'h7020);
		tdone("registers");
		for (k = 0; k < 5; k++)
		begin
			wr(ADDR_RESET_CTRL, 32'h3);
			ev(k);
			t0 = cyc;
			wait_rel;
			`CHK((cyc - t0) <= 12, 1'b1)
			rd(ADDR_RESET_CTRL, {16'h0, wexp[k]});
		end
		sleep_mode <= 1'b1;
		wr(ADDR_RESET_CTRL, 32'h3);
		ev(0);
		wait_rel;
		rd(ADDR_RESET_CTRL, 32'h8B);
		wr(ADDR_RESET_CTRL, 32'h3);
		t0 = cyc;
		ev(1);
		repeat (4) @(posedge clk);
		`CHK(system_reset, 1'b0)
		`CHK(tw > t0, 1'b1)
		rd(ADDR_RESET_CTRL, 32'h1B);
		sleep_mode <= 1'b0;
		wr(ADDR_RESET_CTRL, 32'h0);
		pin_low <= 1'b1;
		repeat (1 + $urandom % 30) @(posedge clk);
		pin_low <= 1'b0;
		repeat (4) @(posedge clk);
		`CHK(system_reset, 1'b0)
		rd(ADDR_RESET_CTRL, 32'h0);
		tdone("warm");
		// Dead crystal with monitor on: trap and fall back
		osc_dead <= 1'b1;
		t0 = cyc;
		cold(32'h0007_071D, 6, 4);
		`CHK(tt > t0, 1'b1)
		`CHK(clock_select, 3'h1)
		rd(ADDR_OSC_CTRL, 32'h1008);
		rd(ADDR_RESET_CTRL, 32'h3);
		wr(ADDR_CONFIG, 32'h0007_0719);
		ev(6);
		repeat (6000) @(posedge clk);
		`CHK(system_reset, 1'b1)
		osc_dead <= 1'b0;
		t0 = cyc;
		wait_rel;
		`CHK((cyc - t0) >= 200 && (cyc - t0) < 260, 1'b1)
		`CHK(clock_select, 3'h7)
		cold(32'h0007_0710, 6, 0);
		t0 = cyc;
		cold(32'h0007_0718, 6, 52);
		`CHK(to > t0, 1'b1)
		wr(ADDR_RESET_CTRL, 32'h8000);
		sleep_mode <= 1'b1;
		osc_dead   <= 1'b1;
		wr(ADDR_CONFIG, 32'h0003_0758);
		ev(5);
		repeat (24000) @(posedge clk);
		`CHK(system_reset, 1'b1)
		osc_dead <= 1'b0;
		t0 = cyc;
		wait_rel;
		`CHK((cyc - t0) >= 220 && (cyc - t0) < 260, 1'b1)
		`CHK(brownout_level, 2'h2)
		`CHK(clock_select, 3'h7)
		rd(ADDR_RESET_CTRL, 32'h8002);
		rd(ADDR_OSC_CTRL, 32'h7020);
		sleep_mode <= 1'b0;
		tdone("cold");
		end_sim;
	end

	// Whole run is near 70000 cycles; cut a hang well past that
	initial
	begin
		#(90000 * 5);
		failures++;
		end_sim;
	end
endmodule : rss_reset_source_sequencer_tb_top

`default_nettype wire
